/* File: src/floppy_glue.sv */
`timescale 1ns/1ps

// Summary of operation
// - Fixed 125 ns precompensation delay on write data
// - Wait bit 6 set: wait released by data request
// - Transfer end raises NMI from controller interrupt
// - Answer only ports E4h and F0h-F4h
// - Host transceiver drives CPU on any read strobe
// - Controller buffer always on, direction by disk read
// - NMI mask write latches bits 6,7 at end
// - Controller interrupt reaches NMI only with bit 7
// - Motor time-out reaches NMI only with bit 6
// - Status read: active-low irq, time-out, reset flags
// - Drive latch written at end of its strobe
// - Bits 0-3 pick drives, bit 4 side
// - Bit 7 double density, bit 5 precompensation
// - Each drive latch write restarts 3 s timer
// - Motor timer expiry clears drive latch
// - Wait-enabled write waits for irq, request, reset
// - Watchdog ends any wait within 1024 us
// - Plain drive write: wait ends after two ticks
// - Oscillator halved for controller, divided for watchdog
// - Write data pulses stretched to about 500 ns
module floppy_glue #(
  parameter int unsigned MOTOR_ON_CYCLES = fdc_glue_pkg::MOTOR_ON_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic cpu_iorq_n_i,
  input wire logic cpu_rd_n_i,
  input wire logic cpu_wr_n_i,
  input wire logic [7:0] cpu_addr_i,
  input wire logic [7:0] cpu_data_i,
  output logic [7:0] cpu_data_o,
  output logic cpu_data_oe_o,
  input wire logic serial_read_strobe_n_i,
  input wire logic interrupt_status_read_strobe_n_i,
  input wire logic reset_button_i,
  output logic cpu_wait_n_o,
  output logic cpu_nmi_n_o,
  output logic xcvr_to_cpu_o,
  input wire logic [7:0] fdc_data_i,
  output logic [7:0] fdc_data_o,
  output logic fdc_data_oe_o,
  output logic [1:0] fdc_addr_o,
  output logic fdc_cs_n_o,
  output logic fdc_rd_n_o,
  output logic fdc_wr_n_o,
  output logic fdc_buf_en_o,
  output logic fdc_buf_to_bus_o,
  output logic fdc_precomp_o,
  output logic fdc_clk_o,
  input wire logic controller_irq_i,
  input wire logic controller_data_request_i,
  input wire logic fdc_write_data_i,
  input wire logic osc_16m_i,
  output logic [3:0] drive_select_o,
  output logic side_select_o,
  output logic single_density_select_o,
  output logic motor_on_o,
  output logic disk_write_data_o
);

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  // every pin passes two flops; only sync_q is read by logic
  logic [fdc_glue_pkg::SYNC_W-1:0] sync_meta;
  logic [fdc_glue_pkg::SYNC_W-1:0] sync_q;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync_meta <= fdc_glue_pkg::SYNC_IDLE;
      sync_q <= fdc_glue_pkg::SYNC_IDLE;
    end else begin
      sync_meta <= {cpu_iorq_n_i, cpu_rd_n_i, cpu_wr_n_i, cpu_addr_i, cpu_data_i,
                    serial_read_strobe_n_i, interrupt_status_read_strobe_n_i,
                    controller_irq_i, controller_data_request_i, reset_button_i,
                    osc_16m_i, fdc_write_data_i, fdc_data_i};
      sync_q <= sync_meta;
    end
  end

  logic iorq_n, rd_n, wr_n, ser_rd_n, int_rd_n, controller_irq;
  logic controller_data_request, rst_btn, osc, wd_in;
  logic [7:0] addr, wdata, fdc_rdata;
  assign {iorq_n, rd_n, wr_n, addr, wdata, ser_rd_n, int_rd_n, controller_irq,
          controller_data_request, rst_btn, osc, wd_in, fdc_rdata} = sync_q;

  function automatic logic is_port(input logic [7:0] a, input logic [7:0] p);
    is_port = (a == p);
  endfunction

  // port decode; the whole 8-bit address must match, except bits 1:0 for the four controller ports
  logic io_rd, io_wr, sel_nmi, sel_fdc, sel_drv;
  assign io_rd = !iorq_n && !rd_n;
  assign io_wr = !iorq_n && !wr_n;
  assign sel_nmi = is_port(addr, fdc_glue_pkg::PORT_NMI);
  assign sel_fdc = is_port({addr[7:2], 2'h0}, fdc_glue_pkg::PORT_FDC_BASE);
  assign sel_drv = is_port(addr, fdc_glue_pkg::PORT_DRIVE);

  logic disk_read_strobe, nmi_status_read_strobe, nmi_mask_write_strobe;
  logic drive_latch_write_strobe, fdc_write_strobe;
  assign disk_read_strobe = sel_fdc && io_rd;
  assign fdc_write_strobe = sel_fdc && io_wr;
  assign nmi_status_read_strobe = sel_nmi && io_rd;
  assign nmi_mask_write_strobe = sel_nmi && io_wr;
  assign drive_latch_write_strobe = sel_drv && io_wr;

  // strobe history; latching happens on the trailing (rising) edge
  logic mask_wr_q, drv_wr_q;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mask_wr_q <= 1'b0;
      drv_wr_q <= 1'b0;
    end else begin
      mask_wr_q <= nmi_mask_write_strobe;
      drv_wr_q <= drive_latch_write_strobe;
    end
  end

  logic mask_wr_end, drv_wr_end, drv_wr_start;
  assign mask_wr_end = mask_wr_q && !nmi_mask_write_strobe;
  assign drv_wr_end = drv_wr_q && !drive_latch_write_strobe;
  assign drv_wr_start = drive_latch_write_strobe && !drv_wr_q;

  // hold write data while the strobe is low; the bus may change as it rises
  logic [7:0] wr_hold;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) wr_hold <= 8'h00;
    else if (io_wr) wr_hold <= wdata;
  end

  // nmi enable mask: [1] controller interrupt, [0] motor time-out
  logic [1:0] nmi_mask;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) nmi_mask <= fdc_glue_pkg::NMI_MASK_RESET;
    else if (mask_wr_end) begin
      nmi_mask <= {wr_hold[fdc_glue_pkg::NMI_EN_FDC_BIT],
                   wr_hold[fdc_glue_pkg::NMI_EN_MOTOR_BIT]};
    end
  end

  a_mask_latch: assert property (mask_wr_end |=> nmi_mask == $past(wr_hold[7:6]))
    else $error("nmi mask not latched at strobe end");

  // motor-on one-shot, restarted by every drive latch write
  logic motor_expire;
  retrig_one_shot #(
    .LEN(MOTOR_ON_CYCLES)
  ) u_motor (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .trig_i(drv_wr_end),
    .active_o(motor_on_o),
    .expire_o(motor_expire)
  );

  a_motor_run: assert property (drv_wr_end |=> motor_on_o)
    else $error("motor not started by drive latch write");

  // drive select latch; a new write beats expiry in the same cycle
  logic [7:0] dsel;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) dsel <= fdc_glue_pkg::DSEL_RESET;
    else if (drv_wr_end) dsel <= wr_hold;
    else if (motor_expire) dsel <= fdc_glue_pkg::DSEL_RESET;
  end

  // drive bits go out as written; software keeps at most one set
  assign drive_select_o = dsel[3:0];
  assign side_select_o = dsel[fdc_glue_pkg::DSEL_SIDE_BIT];
  assign single_density_select_o = !dsel[fdc_glue_pkg::DSEL_MFM_BIT];
  assign fdc_precomp_o = dsel[fdc_glue_pkg::DSEL_PRECOMP_BIT];

  a_drive_latch: assert property (drv_wr_end |=> dsel == $past(wr_hold))
    else $error("drive latch not loaded at strobe end");

  sequence s_motor_expiry;
    motor_expire && !motor_on_o;
  endsequence

  // a latch write in the expiry cycle wins, so that cycle is left out
  a_motor_clear: assert property (motor_expire && !drv_wr_end
    |-> s_motor_expiry ##1 dsel == 8'h00)
    else $error("drive latch not cleared on motor time-out");

  // motor time-out flag stays until the next drive latch write
  logic motor_timeout;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) motor_timeout <= 1'b0;
    else if (motor_expire) motor_timeout <= 1'b1;
    else if (drv_wr_end) motor_timeout <= 1'b0;
  end

  // nmi is a level: held while any enabled source is present
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) cpu_nmi_n_o <= 1'b1;
    else cpu_nmi_n_o <= !((nmi_mask[1] && controller_irq)
                          || (nmi_mask[0] && motor_timeout));
  end

  a_nmi_fdc: assert property ((nmi_mask[1] && controller_irq) [*2] |-> !cpu_nmi_n_o)
    else $error("enabled controller interrupt gave no nmi");

  a_nmi_motor: assert property ((nmi_mask[0] && motor_timeout) [*2] |-> !cpu_nmi_n_o)
    else $error("enabled motor time-out gave no nmi");

  a_nmi_idle: assert property (
    (!(nmi_mask[1] && controller_irq) && !(nmi_mask[0] && motor_timeout)) [*2]
    |-> cpu_nmi_n_o)
    else $error("nmi asserted with no enabled source");

  // source status, active low; unused bits read zero
  logic [7:0] nmi_status;
  always_comb begin
    nmi_status = 8'h00;
    nmi_status[fdc_glue_pkg::STAT_IRQ_BIT] = !controller_irq;
    nmi_status[fdc_glue_pkg::STAT_MOTOR_BIT] = !motor_timeout;
    nmi_status[fdc_glue_pkg::STAT_RESET_BIT] = !rst_btn;
  end

  // cpu read data and pin enable; unmapped ports leave the bus alone
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cpu_data_o <= 8'h00;
      cpu_data_oe_o <= 1'b0;
    end else begin
      cpu_data_oe_o <= disk_read_strobe || nmi_status_read_strobe;
      if (disk_read_strobe) cpu_data_o <= fdc_rdata;
      else if (nmi_status_read_strobe) cpu_data_o <= nmi_status;
      else cpu_data_o <= 8'h00;
    end
  end

  a_status_read: assert property (nmi_status_read_strobe
    |=> cpu_data_oe_o && cpu_data_o[7] == !$past(controller_irq))
    else $error("status read returned wrong irq flag");

  a_unmapped: assert property ((io_rd && !sel_nmi && !sel_fdc) |=> !cpu_data_oe_o)
    else $error("unmapped port read drove the bus");

  // shared cpu-side transceiver turns toward the cpu on controller and status port reads and on the serial and interrupt-status read strobes
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) xcvr_to_cpu_o <= 1'b0;
    else xcvr_to_cpu_o <= disk_read_strobe || nmi_status_read_strobe
                          || !ser_rd_n || !int_rd_n;
  end

  a_xcvr_dir: assert property ((!ser_rd_n || !int_rd_n || disk_read_strobe)
    |=> xcvr_to_cpu_o)
    else $error("transceiver not turned toward cpu on read");

  // controller chip side; its buffer is never disabled
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fdc_cs_n_o <= 1'b1;
      fdc_rd_n_o <= 1'b1;
      fdc_wr_n_o <= 1'b1;
      fdc_addr_o <= 2'h0;
      fdc_data_o <= 8'h00;
      fdc_data_oe_o <= 1'b1;
      fdc_buf_en_o <= 1'b1;
      fdc_buf_to_bus_o <= 1'b0;
    end else begin
      fdc_cs_n_o <= !(disk_read_strobe || fdc_write_strobe);
      fdc_rd_n_o <= !disk_read_strobe;
      fdc_wr_n_o <= !fdc_write_strobe;
      fdc_addr_o <= addr[1:0];
      fdc_data_o <= wdata;
      fdc_data_oe_o <= !disk_read_strobe;
      fdc_buf_en_o <= 1'b1;
      fdc_buf_to_bus_o <= disk_read_strobe;
    end
  end

  a_buf_dir: assert property (disk_read_strobe
    |=> fdc_buf_to_bus_o && fdc_buf_en_o && !fdc_data_oe_o)
    else $error("controller buffer not turned toward bus");

  a_fdc_read: assert property (disk_read_strobe |=> !fdc_cs_n_o && !fdc_rd_n_o)
    else $error("controller register read not passed on");

  // oscillator edges: halve for the controller, prescale for the watchdog
  logic osc_q, osc_rise, tick;
  logic [3:0] prescale;
  assign osc_rise = osc && !osc_q;
  assign tick = osc_rise && (prescale == fdc_glue_pkg::OSC_PER_TICK_M1);
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      osc_q <= 1'b0;
      fdc_clk_o <= 1'b0;
    end else begin
      osc_q <= osc;
      if (osc_rise) fdc_clk_o <= !fdc_clk_o;
    end
  end

  a_fdc_clk: assert property (osc_rise |=> fdc_clk_o != $past(fdc_clk_o))
    else $error("controller clock missed an oscillator edge");

  // wait generator; prescaler restarts at entry so tick counts are exact
  fdc_glue_pkg::wait_state_e wstate;
  logic [10:0] wticks;
  logic wait_watchdog_timeout;
  assign wait_watchdog_timeout = (wticks == fdc_glue_pkg::WAIT_LIMIT_TICKS);

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) prescale <= 4'h0;
    else if (drv_wr_start || osc_rise && tick) prescale <= 4'h0;
    else if (osc_rise) prescale <= prescale + 4'h1;
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wstate <= fdc_glue_pkg::WAIT_IDLE;
      wticks <= 11'h000;
      cpu_wait_n_o <= 1'b1;
    end else if (drv_wr_start) begin
      wticks <= 11'h000;
      cpu_wait_n_o <= 1'b0;
      if (wdata[fdc_glue_pkg::DSEL_WAIT_BIT]) wstate <= fdc_glue_pkg::WAIT_LONG;
      else wstate <= fdc_glue_pkg::WAIT_SHORT;
    end else begin
      if (tick && wstate != fdc_glue_pkg::WAIT_IDLE) wticks <= wticks + 11'h001;
      case (wstate)
        fdc_glue_pkg::WAIT_SHORT: begin
          if (wticks == fdc_glue_pkg::SHORT_WAIT_TICKS) begin
            wstate <= fdc_glue_pkg::WAIT_IDLE;
            cpu_wait_n_o <= 1'b1;
          end
        end
        fdc_glue_pkg::WAIT_LONG: begin
          // a dead controller must not starve dram refresh
          if (controller_irq || controller_data_request || rst_btn
              || wait_watchdog_timeout) begin
            wstate <= fdc_glue_pkg::WAIT_IDLE;
            cpu_wait_n_o <= 1'b1;
          end
        end
        default: begin
          cpu_wait_n_o <= 1'b1;
        end
      endcase
    end
  end

  a_wait_entry: assert property (drv_wr_start |=> !cpu_wait_n_o)
    else $error("drive latch write did not start a wait");

  sequence s_short_done;
    wstate == fdc_glue_pkg::WAIT_SHORT && wticks == 11'h002 && !drv_wr_start;
  endsequence

  a_short_wait: assert property (s_short_done |=> cpu_wait_n_o)
    else $error("short wait not released after two ticks");

  sequence s_long_cause;
    wstate == fdc_glue_pkg::WAIT_LONG && !drv_wr_start
    && (controller_irq || controller_data_request);
  endsequence

  a_wait_release: assert property (s_long_cause |=> cpu_wait_n_o)
    else $error("wait not released by controller request");

  a_wait_hold: assert property ((wstate == fdc_glue_pkg::WAIT_LONG && !controller_irq
    && !controller_data_request && !rst_btn && wticks < 11'd1024 && !drv_wr_start)
    |=> !cpu_wait_n_o)
    else $error("long wait released early");

  a_wd_limit: assert property ((wticks == fdc_glue_pkg::WAIT_LIMIT_TICKS
    && wstate == fdc_glue_pkg::WAIT_LONG && !drv_wr_start) |=> cpu_wait_n_o)
    else $error("watchdog failed to end the wait");

  a_wd_bound: assert property (wstate == fdc_glue_pkg::WAIT_LONG
    |-> wticks <= fdc_glue_pkg::WAIT_LIMIT_TICKS)
    else $error("long wait ran past the watchdog limit");

  // write data: optional fixed precompensation delay, then stretched
  logic [fdc_glue_pkg::PRECOMP_CYCLES-1:0] wd_dly;
  logic wd_src, wd_src_q, wd_rise;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wd_dly <= '0;
      wd_src_q <= 1'b0;
    end else begin
      wd_dly <= {wd_dly[fdc_glue_pkg::PRECOMP_CYCLES-2:0], wd_in};
      wd_src_q <= wd_src;
    end
  end

  // delay is fixed: no register sets the amount
  assign wd_src = dsel[fdc_glue_pkg::DSEL_PRECOMP_BIT]
                  ? wd_dly[fdc_glue_pkg::PRECOMP_CYCLES-1] : wd_in;
  assign wd_rise = wd_src && !wd_src_q;

  retrig_one_shot #(
    .LEN(fdc_glue_pkg::WD_PULSE_CYCLES)
  ) u_wd_stretch (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .trig_i(wd_rise),
    .active_o(disk_write_data_o),
    .expire_o()
  );

  a_precomp: assert property ($rose(wd_in) |-> ##16 wd_dly[15])
    else $error("precompensation delay is not 16 cycles");

  a_wd_stretch: assert property (wd_rise |=> disk_write_data_o [*8])
    else $error("write data pulse not stretched");

endmodule // floppy_glue

/* File: src/fdc_glue_pkg.sv */
package fdc_glue_pkg;

  // port map
  localparam logic [7:0] PORT_NMI = 8'he4;
  localparam logic [7:0] PORT_FDC_BASE = 8'hf0;
  localparam logic [7:0] PORT_DRIVE = 8'hf4;

  // nmi enable mask and source status fields
  localparam int NMI_EN_FDC_BIT = 7;
  localparam int NMI_EN_MOTOR_BIT = 6;
  localparam int STAT_IRQ_BIT = 7;
  localparam int STAT_MOTOR_BIT = 6;
  localparam int STAT_RESET_BIT = 5;
  localparam logic [1:0] NMI_MASK_RESET = 2'h0;

  // drive select latch fields
  localparam int DSEL_SIDE_BIT = 4;
  localparam int DSEL_PRECOMP_BIT = 5;
  localparam int DSEL_WAIT_BIT = 6;
  localparam int DSEL_MFM_BIT = 7;
  localparam logic [7:0] DSEL_RESET = 8'h00;

  // system clock
  localparam int CLK_PERIOD_NS = 8;
  localparam int CLK_MHZ = 125;

  // write path timing, least times rounded up to whole cycles
  localparam int PRECOMP_NS = 125;
  localparam int PRECOMP_CYCLES = (PRECOMP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WD_PULSE_NS = 500;
  localparam int WD_PULSE_CYCLES = (WD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // motor-on one-shot
  localparam int unsigned MOTOR_ON_MS = 3000;
  localparam int unsigned MOTOR_ON_CYCLES = MOTOR_ON_MS * CLK_MHZ * 1000;

  // watchdog timebase derived from the 16 MHz oscillator
  localparam int OSC_MHZ = 16;
  localparam int TICK_US = 1;
  localparam logic [3:0] OSC_PER_TICK_M1 = 4'(OSC_MHZ * TICK_US - 1);
  localparam int WAIT_LIMIT_US = 1024;
  localparam logic [10:0] WAIT_LIMIT_TICKS = 11'(WAIT_LIMIT_US / TICK_US);
  localparam logic [10:0] SHORT_WAIT_TICKS = 11'h002;

  // input synchroniser: width and idle value (active-low pins idle high)
  localparam int SYNC_W = 34;
  localparam logic [SYNC_W-1:0] SYNC_IDLE = 34'h380006000;

  typedef enum logic [1:0] {WAIT_IDLE, WAIT_SHORT, WAIT_LONG} wait_state_e;

endpackage

/* File: src/retrig_one_shot.sv */
`timescale 1ns/1ps

// retriggerable one-shot: active for LEN cycles after the last trigger
module retrig_one_shot #(
  parameter int unsigned LEN = 2
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic trig_i,
  output logic active_o,
  output logic expire_o
);

  localparam int CW = $clog2(LEN + 1);

  logic [CW-1:0] cnt;

  // a trigger reloads the count, so a busy one-shot simply stretches
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt <= '0;
      active_o <= 1'b0;
      expire_o <= 1'b0;
    end else if (trig_i) begin
      cnt <= CW'(LEN);
      active_o <= 1'b1;
      expire_o <= 1'b0;
    end else if (cnt != '0) begin
      cnt <= cnt - 1'b1;
      active_o <= (cnt != 1'b1);
      expire_o <= (cnt == 1'b1);
    end else begin
      expire_o <= 1'b0;
    end
  end

endmodule // retrig_one_shot

/* File: verif/fdc_model.sv */
`timescale 1ns/1ps

// controller chip stand-in: four byte registers behind the glue's local bus
module fdc_model (
  input wire logic sys_clk_i,
  input wire logic [1:0] addr_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o
);
  logic [7:0] regs [4] = '{8'ha0, 8'ha1, 8'ha2, 8'ha3};
  logic [7:0] last = 8'h00;

  // store on write; remember the last byte driven so a released bus never repeats it
  always @(posedge sys_clk_i) begin
    if (!cs_n_i && !wr_n_i) regs[addr_i] <= data_i;
    if (!cs_n_i && !rd_n_i) last <= regs[addr_i];
  end
  assign data_o = (!cs_n_i && !rd_n_i) ? regs[addr_i] : ~last;
endmodule // fdc_model

/* File: verif/floppy_glue_tb.sv */
`timescale 1ns/1ps

module floppy_glue_tb;
  logic sys_clk = 1'b0;
  logic osc = 1'b0;
  logic resetn = 1'b0;
  logic iorq_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1, ser_n = 1'b1, ints_n = 1'b1;
  logic rst_btn = 1'b0, irq = 1'b0, dreq = 1'b0, wdat = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, cpu_q, fdc_q, fdc_d, rq, d;
  logic oe, wait_n, nmi_n, xcvr, fdc_oe, cs_n, frd_n, fwr_n, buf_en, to_bus;
  logic pcomp, fclk, sden, side, motor, dout, roe, prev;
  logic [1:0] fa;
  logic [3:0] dsel;
  int error_cnt = 0, n_checks = 0, seed = 52;
  int m_mask = 0, m_latch = 0, m_mto = 0;  // behavioural model of the latches
  int wcyc, n, lat0, lat1, w;

  floppy_glue #(.MOTOR_ON_CYCLES(600)) floppy_glue_i (
    .sys_clk_i(sys_clk), .resetn_i(resetn), .cpu_iorq_n_i(iorq_n), .cpu_rd_n_i(rd_n),
    .cpu_wr_n_i(wr_n), .cpu_addr_i(addr), .cpu_data_i(wdata), .cpu_data_o(cpu_q),
    .cpu_data_oe_o(oe), .serial_read_strobe_n_i(ser_n),
    .interrupt_status_read_strobe_n_i(ints_n), .reset_button_i(rst_btn),
    .cpu_wait_n_o(wait_n), .cpu_nmi_n_o(nmi_n), .xcvr_to_cpu_o(xcvr), .fdc_data_i(fdc_q),
    .fdc_data_o(fdc_d), .fdc_data_oe_o(fdc_oe), .fdc_addr_o(fa), .fdc_cs_n_o(cs_n),
    .fdc_rd_n_o(frd_n), .fdc_wr_n_o(fwr_n), .fdc_buf_en_o(buf_en),
    .fdc_buf_to_bus_o(to_bus), .fdc_precomp_o(pcomp), .fdc_clk_o(fclk),
    .controller_irq_i(irq), .controller_data_request_i(dreq), .fdc_write_data_i(wdat),
    .osc_16m_i(osc), .drive_select_o(dsel), .side_select_o(side),
    .single_density_select_o(sden), .motor_on_o(motor), .disk_write_data_o(dout));

  fdc_model fdc_model_i (.sys_clk_i(sys_clk), .addr_i(fa), .cs_n_i(cs_n), .rd_n_i(frd_n),
    .wr_n_i(fwr_n), .data_i(fdc_d), .data_o(fdc_q));

  // oscillator free-runs with no phase tie to the system clock
  always #4 sys_clk = ~sys_clk;
  always #31.25 osc = ~osc;

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (e !== g) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge sys_clk);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // one port cycle; the strobe stays down while wait is low, as a real cpu would
  task automatic io(input logic [7:0] a, input bit wr, input logic [7:0] dv, input int rel,
                    input int src);
    @(negedge sys_clk);
    addr = a;
    wdata = dv;
    iorq_n = 1'b0;
    rd_n = wr;
    wr_n = !wr;
    // controller read data crosses two sync flops after its strobe, so look late
    cyc(7);
    rq = cpu_q;
    roe = oe;
    chk("buf_en", 1, buf_en);
    if (a[7:2] == 6'h3c) begin
      chk("fdc_addr", a[1:0], fa);
      chk("to_bus", !wr, to_bus);
      chk("fdc_oe", wr, fdc_oe);
      if (wr) chk("fdc_wdata", dv, fdc_d);
    end
    wcyc = 0;
    while (wait_n !== 1'b1) begin
      if (wcyc == rel) begin
        case (src)
          0: dreq = 1'b1;
          1: irq = 1'b1;
          default: rst_btn = 1'b1;
        endcase
      end
      wcyc++;
      if (wcyc > 2000) begin
        chk("wait bound", 0, 1);
        stop_test();
      end
      @(negedge sys_clk);
    end
    iorq_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    cyc(4);
  endtask

  task automatic dsel_wr(input logic [7:0] dv, input int rel, input int src);
    io(8'hf4, 1, dv, rel, src);
    m_latch = dv;
    m_mto = 0;
  endtask

  task automatic latch_chk;
    chk("dsel", m_latch & 15, dsel);
    chk("side", m_latch[4], side);
    chk("precomp", m_latch[5], pcomp);
    chk("sden", !m_latch[7], sden);
  endtask

  // one controller write pulse; reports latency and stretched width
  task automatic wpulse(output int lat);
    wdat = 1'b1;
    @(negedge sys_clk);
    wdat = 1'b0;
    lat = 1;
    while (dout !== 1'b1 && lat < 100) begin
      @(negedge sys_clk);
      lat++;
    end
    w = 0;
    while (dout === 1'b1 && w < 200) begin
      @(negedge sys_clk);
      w++;
    end
    chk("pulse width", 63, w);
  endtask

  initial begin
    cyc(6);
    resetn = 1'b1;
    latch_chk();
    chk("wait_n", 1, wait_n);
    chk("nmi_n", 1, nmi_n);
    chk("motor", 0, motor);
    cyc(2);
    // controller registers are reached at f0..f3 only
    for (int i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      io(8'(8'hf0 + i), 1, d, -1, 0);
      io(8'(8'hf0 + i), 0, 8'h00, -1, 0);
      chk("fdc read", {1'b1, d}, {roe, rq});
    end
    repeat (8) begin
      d = 8'($random(seed));
      if (d == 8'he4 || d[7:2] == 6'h3c) d = 8'hf4;
      io(d, 0, 8'h00, -1, 0);
      chk("foreign oe", 0, roe);
    end
    $display("test ports done");
    // shared transceiver turns toward the cpu on either outside read strobe
    ser_n = 1'b0;
    cyc(4);
    chk("xcvr serial", 1, xcvr);
    ser_n = 1'b1;
    ints_n = 1'b0;
    cyc(4);
    chk("xcvr int", 1, xcvr);
    ints_n = 1'b1;
    cyc(4);
    chk("xcvr idle", 0, xcvr);
    $display("test transceiver done");
    // every mask pair against irq, reset set along with mask bit 6, junk in the low bits
    for (int i = 0; i < 8; i++) begin
      irq = i[2];
      rst_btn = i[0];
      d = 8'($random(seed));
      d[7:6] = 2'(i);
      m_mask = d & 8'hc0;
      io(8'he4, 1, d, -1, 0);
      io(8'he4, 0, 8'h00, -1, 0);
      chk("status", {1'b1, !irq, m_mto == 0, !rst_btn, 5'h0}, {roe, rq});
      chk("nmi irq", !(m_mask[7] && irq), nmi_n);
    end
    irq = 1'b0;
    rst_btn = 1'b0;
    io(8'he4, 1, 8'h00, -1, 0);
    m_mask = 0;
    $display("test nmi done");
    // short wait, then the write data path with and without precompensation
    dsel_wr(8'h21, -1, 0);
    chk("short wait", 1, wcyc >= 230 && wcyc <= 270);
    latch_chk();
    chk("motor", 1, motor);
    wpulse(lat1);
    dsel_wr(8'h01, -1, 0);
    wpulse(lat0);
    chk("precomp delay", 16, lat1 - lat0);
    // long waits ended by data request, controller irq and reset in turn
    for (int i = 0; i < 3; i++) begin
      dsel_wr(8'(8'h40 | (1 << i)), 100, i);
      chk("long wait", 1, wcyc >= 100 && wcyc <= 106);
      latch_chk();
      dreq = 1'b0;
      irq = 1'b0;
      rst_btn = 1'b0;
    end
    $display("test waits done");
    // retrigger keeps the motor on, expiry clears the latch and flags the time-out
    io(8'he4, 1, 8'h40, -1, 0);
    m_mask = 8'h40;
    dsel_wr(8'h92, -1, 0);
    cyc(250);
    dsel_wr(8'h92, -1, 0);
    cyc(200);
    chk("motor retrig", 1, motor);
    latch_chk();
    cyc(420);
    m_latch = 0;
    m_mto = 1;
    chk("motor off", 0, motor);
    latch_chk();
    chk("nmi timeout", 0, nmi_n);
    io(8'he4, 0, 8'h00, -1, 0);
    chk("status to", {1'b1, !irq, m_mto == 0, !rst_btn, 5'h0}, {roe, rq});
    io(8'he4, 1, 8'h00, -1, 0);
    cyc(2);
    chk("nmi masked", 1, nmi_n);
    $display("test motor done");
    // controller clock: 8 MHz gives about 51 rises in 6.4 us
    n = 0;
    prev = fclk;
    repeat (800) begin
      @(negedge sys_clk);
      if (fclk && !prev) n++;
      prev = fclk;
    end
    chk("fdc clock", 1, n >= 50 && n <= 53);
    $display("test clock done");
    stop_test();
  end
endmodule // floppy_glue_tb
